/* core/msf_defines.svh */
`ifndef MSF_DEFINES_SVH
`define MSF_DEFINES_SVH

// Characters
`define MSF_COLON      8'h3A
`define MSF_CR         8'h0D
`define MSF_LF         8'h0A
`define MSF_CHAR_0     8'h30
`define MSF_CHAR_9     8'h39
`define MSF_CHAR_A     8'h41
`define MSF_CHAR_F     8'h46
`define MSF_ALPHA_OFS  8'h37
`define MSF_HEX_ADJ    4'h9

// Addresses and functions
`define MSF_BCAST      8'h00
`define MSF_FN_READ    8'h03
`define MSF_FN_WRITE   8'h06
`define MSF_EXC_FLAG   8'h80
`define MSF_EXC_DATA   8'h01
`define MSF_EXC_ADDR   8'h02
`define MSF_EXC_FRAME  8'h0B
`define MSF_EXC_PARITY 8'h0C

// Frame sizes in bytes
`define MSF_ASCII_MAXB 5'h13
`define MSF_RTU_MAXB   5'h14
`define MSF_ASCII_OVH  5'h03
`define MSF_RTU_OVH    5'h04
`define MSF_REQ_DLEN   5'h04
`define MSF_MAX_WORDS  8'h08
`define MSF_BUF_N      6

// Check values
`define MSF_CRC_INIT   16'hFFFF
`define MSF_CRC_POLY   16'hA001

// Word frame lengths
`define MSF_ASCII_BITS 4'hA
`define MSF_RTU_BITS   4'hB

// Timing
`define MSF_CLK_HZ     100000000
`define MSF_GAP_MS     10
`define MSF_GAP_CYC    ((`MSF_GAP_MS * `MSF_CLK_HZ + 999) / 1000)
`define MSF_FIFO_DEPTH 8

`endif

/* core/msf_pkg.sv */
`default_nettype none
package msf_pkg;

  // Sequencer states
  typedef enum logic [6:0] {
    ST_RX    = 7'b0000001,
    ST_EXEC  = 7'b0000010,
    ST_FETCH = 7'b0000100,
    ST_START = 7'b0001000,
    ST_EMIT  = 7'b0010000,
    ST_TRAIL = 7'b0100000,
    ST_DRAIN = 7'b1000000
  } msf_state_t;

  // Reply kinds
  typedef enum logic [2:0] {
    RK_RD = 3'b001,
    RK_WR = 3'b010,
    RK_EX = 3'b100
  } msf_kind_t;

endpackage
`default_nettype wire

/* core/msf_stream_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface msf_stream_if #(parameter int W = 8);
  logic [W-1:0] data;
  logic         valid;
  logic         ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface
`default_nettype wire

/* core/msf_crc16.sv */
`include "msf_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module msf_crc16 import msf_pkg::*; (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // Byte input
  input  wire logic        init,
  input  wire logic        en,
  input  wire logic [7:0]  data,
  // Running value
  output logic      [15:0] crc_q
);

  // One byte through the reflected polynomial
  function automatic logic [15:0] crcStep(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ `MSF_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  // Init and a byte in the same cycle start a fresh frame with that byte
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      crc_q <= `MSF_CRC_INIT;
    end else if (en) begin
      crc_q <= crcStep(init ? `MSF_CRC_INIT : crc_q, data);
    end else if (init) begin
      crc_q <= `MSF_CRC_INIT;
    end
  end

endmodule
`default_nettype wire

/* core/msf_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module msf_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst,
  // Streams
  msf_stream_if.snk inp,
  msf_stream_if.src outp
);

  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem_q [DEPTH];
  logic [AW:0]  wrPtr_q;
  logic [AW:0]  rdPtr_q;
  logic         full;
  logic         empty;

  // Extra pointer bit tells full from empty; depth must be a power of two
  assign full       = (wrPtr_q[AW] != rdPtr_q[AW]) && (wrPtr_q[AW-1:0] == rdPtr_q[AW-1:0]);
  assign empty      = (wrPtr_q == rdPtr_q);
  assign inp.ready  = !full;
  assign outp.valid = !empty;
  assign outp.data  = mem_q[rdPtr_q[AW-1:0]];

  // Storage
  always_ff @(posedge ref_clk) begin
    if (inp.valid && !full) begin
      mem_q[wrPtr_q[AW-1:0]] <= inp.data;
    end
  end

  // Pointers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
    end else begin
      if (inp.valid && !full) begin
        wrPtr_q <= wrPtr_q + 1'b1;
      end
      if (outp.ready && !empty) begin
        rdPtr_q <= rdPtr_q + 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

/* core/msf_framer.sv */
`include "msf_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module msf_framer import msf_pkg::*; #(
  parameter int unsigned GAP_CYCLES = `MSF_GAP_CYC,
  parameter int          FIFO_DEPTH = `MSF_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // Mode and identity
  input  wire logic        asciiMode,
  input  wire logic [7:0]  stationAddr,
  output logic      [3:0]  charBits,
  // Received characters
  input  wire logic        rxValid,
  input  wire logic [7:0]  rxData,
  input  wire logic        rxFrameErr,
  input  wire logic        rxParityErr,
  // Transmitted characters
  output logic             txValid,
  output logic      [7:0]  txData,
  input  wire logic        txReady,
  // Register access
  output logic             regReq,
  output logic             regWrite,
  output logic      [15:0] regAddr,
  output logic      [15:0] regWData,
  input  wire logic        regAck,
  input  wire logic [15:0] regRData,
  input  wire logic        regAddrErr,
  input  wire logic        regDataErr,
  // Status
  output logic             frameDone,
  output logic             frameDropped
);

  localparam int GW = $clog2(GAP_CYCLES + 1);

  msf_state_t  state_q;
  msf_kind_t   kind_q;
  logic [GW-1:0] gapCnt_q;
  logic        gapHit, quiet_q;
  logic        rxAct_q, nibHi_q, sawCr_q, bad_q, frmErr_q, parErr_q;
  logic [3:0]  nib_q;
  logic [4:0]  rxCnt_q;
  logic [7:0]  lrc_q;
  logic [7:0]  buf_q [`MSF_BUF_N];
  logic [15:0] rxCrc, txCrc;
  logic        inRx, isColon, startRx, asciiHex, pushByte, rxEnd;
  logic [7:0]  pushVal;
  logic [4:0]  cntBase;
  logic [7:0]  lrcBase;
  logic [7:0]  excCode_q, txLrc_q, word8;
  logic [15:0] word_q;
  logic        wordReady_q, started_q, nibSel_q;
  logic [4:0]  k_q, payLen, dataLen;
  logic [1:0]  tIdx_q;
  logic [3:0]  words;
  logic        checkOk, addrOk, bcast, needFetch, hexMode, chValid, fire, byteDone, lastTrail;
  logic [7:0]  chData, payByte, trailByte, curByte;
  logic        fifoReady;

  msf_stream_if #(.W(8)) chIn ();
  msf_stream_if #(.W(8)) chOut ();

  // Hex helpers
  function automatic logic [7:0] hexChar(input logic [3:0] n);
    return (n < 4'hA) ? (`MSF_CHAR_0 + {4'h0, n}) : (`MSF_ALPHA_OFS + {4'h0, n});
  endfunction

  function automatic logic isHex(input logic [7:0] c);
    return ((c >= `MSF_CHAR_0) && (c <= `MSF_CHAR_9)) ||
           ((c >= `MSF_CHAR_A) && (c <= `MSF_CHAR_F));
  endfunction

  function automatic logic [3:0] hexVal(input logic [7:0] c);
    return (c <= `MSF_CHAR_9) ? c[3:0] : (c[3:0] + `MSF_HEX_ADJ);
  endfunction

  // Silence timer, restarted by any traffic in either direction
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      gapCnt_q <= '0;
      quiet_q  <= 1'b0;
    end else begin
      if (rxValid || (txValid && txReady)) begin
        gapCnt_q <= '0;
      end else if (!gapHit) begin
        gapCnt_q <= gapCnt_q + 1'b1;
      end
      if (rxValid) begin
        quiet_q <= 1'b0;
      end else if (gapHit) begin
        quiet_q <= 1'b1;
      end
    end
  end
  assign gapHit = (gapCnt_q == GW'(GAP_CYCLES));

  // Receive decoding
  assign inRx     = (state_q == ST_RX) && rxValid;
  assign isColon  = asciiMode && (rxData == `MSF_COLON);
  assign startRx  = inRx && (asciiMode ? isColon : (!rxAct_q && (quiet_q || gapHit)));
  assign asciiHex = inRx && asciiMode && rxAct_q && !isColon && !sawCr_q && isHex(rxData);
  assign pushByte = asciiMode ? (asciiHex && nibHi_q) : (inRx && (rxAct_q || startRx));
  assign pushVal  = asciiMode ? {nib_q, hexVal(rxData)} : rxData;
  assign rxEnd    = asciiMode ? (inRx && rxAct_q && sawCr_q && (rxData == `MSF_LF))
                              : ((state_q == ST_RX) && rxAct_q && gapHit);
  assign cntBase  = startRx ? 5'h00 : rxCnt_q;
  assign lrcBase  = startRx ? 8'h00 : lrc_q;

  // Receive frame state; in ASCII mode a colon received in ST_RX wipes what came before
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rxAct_q  <= 1'b0;
      rxCnt_q  <= '0;
      nibHi_q  <= 1'b0;
      nib_q    <= '0;
      sawCr_q  <= 1'b0;
      bad_q    <= 1'b0;
      frmErr_q <= 1'b0;
      parErr_q <= 1'b0;
      lrc_q    <= '0;
    end else if (inRx || rxEnd) begin
      if (startRx) begin
        rxAct_q  <= 1'b1;
        rxCnt_q  <= '0;
        nibHi_q  <= 1'b0;
        sawCr_q  <= 1'b0;
        bad_q    <= 1'b0;
        frmErr_q <= 1'b0;
        parErr_q <= 1'b0;
        lrc_q    <= '0;
      end
      if (inRx && (rxAct_q || startRx)) begin
        if (rxFrameErr) frmErr_q <= 1'b1;
        if (rxParityErr) parErr_q <= 1'b1;
      end
      if (asciiHex && !nibHi_q) begin
        nib_q   <= hexVal(rxData);
        nibHi_q <= 1'b1;
      end
      if (pushByte) begin
        nibHi_q <= 1'b0;
        lrc_q   <= lrcBase + pushVal;
        if (cntBase < (asciiMode ? `MSF_ASCII_MAXB : `MSF_RTU_MAXB)) begin
          rxCnt_q <= cntBase + 5'h01;
        end else begin
          bad_q <= 1'b1;
        end
      end
      if (inRx && asciiMode && rxAct_q && !isColon && !asciiHex) begin
        if ((rxData == `MSF_CR) && !sawCr_q && !nibHi_q) begin
          sawCr_q <= 1'b1;
        end else if (!(sawCr_q && (rxData == `MSF_LF))) begin
          bad_q <= 1'b1;
        end
      end
      if (rxEnd) begin
        rxAct_q <= 1'b0;
      end
    end
  end

  // Header bytes kept for decode and echo
  always_ff @(posedge ref_clk) begin
    if (pushByte && (cntBase < 5'(`MSF_BUF_N))) begin
      buf_q[cntBase[2:0]] <= pushVal;
    end
  end

  msf_crc16 u_rxCrc (
    .ref_clk (ref_clk),
    .rst     (rst),
    .init    (startRx),
    .en      (pushByte),
    .data    (pushVal),
    .crc_q   (rxCrc)
  );

  // Frame checks; a CRC run over its own check bytes leaves zero
  assign checkOk = asciiMode ? ((lrc_q == 8'h00) && (rxCnt_q >= `MSF_ASCII_OVH))
                             : ((rxCrc == 16'h0000) && (rxCnt_q >= `MSF_RTU_OVH));
  assign dataLen = rxCnt_q - (asciiMode ? `MSF_ASCII_OVH : `MSF_RTU_OVH);
  assign bcast   = (buf_q[0] == `MSF_BCAST);
  assign addrOk  = bcast || (buf_q[0] == stationAddr);
  assign words   = buf_q[5][3:0];
  assign payLen  = (kind_q == RK_RD) ? (5'h03 + {words, 1'b0}) :
                   (kind_q == RK_WR) ? 5'h06 : 5'h03;

  // Reply bytes, words high byte first
  assign word8 = k_q[0] ? word_q[15:8] : word_q[7:0];
  always_comb begin
    payByte = 8'h00;
    case (k_q)
      5'h00: payByte = buf_q[0];
      5'h01: payByte = (kind_q == RK_EX) ? (buf_q[1] | `MSF_EXC_FLAG) : buf_q[1];
      5'h02: payByte = (kind_q == RK_EX) ? excCode_q :
                       (kind_q == RK_RD) ? {3'b000, words, 1'b0} : buf_q[2];
      default: payByte = (kind_q == RK_RD) ? word8 : buf_q[k_q[2:0]];
    endcase
  end

  assign trailByte = asciiMode ? ((tIdx_q == 2'h0) ? (~txLrc_q + 8'h01) :
                                  (tIdx_q == 2'h1) ? `MSF_CR : `MSF_LF)
                               : ((tIdx_q == 2'h0) ? txCrc[7:0] : txCrc[15:8]);
  assign curByte   = (state_q == ST_EMIT) ? payByte : trailByte;
  assign needFetch = (kind_q == RK_RD) && (k_q >= 5'h03) && k_q[0] && !wordReady_q;
  // The colon in ST_START must not toggle the nibble select
  assign hexMode   = asciiMode && ((state_q == ST_EMIT) ||
                                   ((state_q == ST_TRAIL) && (tIdx_q == 2'h0)));
  assign lastTrail = (tIdx_q == (asciiMode ? 2'h2 : 2'h1));

  // Character generator feeding the transmit buffer
  always_comb begin
    chValid = 1'b0;
    chData  = 8'h00;
    case (state_q)
      ST_START: begin
        chValid = asciiMode;
        chData  = `MSF_COLON;
      end
      ST_EMIT, ST_TRAIL: begin
        chValid = (state_q == ST_TRAIL) || !needFetch;
        chData  = hexMode ? hexChar(nibSel_q ? curByte[3:0] : curByte[7:4]) : curByte;
      end
      default: begin
        chValid = 1'b0;
      end
    endcase
  end
  assign fire     = chValid && fifoReady;
  assign byteDone = fire && (!hexMode || nibSel_q) && (state_q != ST_START);

  msf_crc16 u_txCrc (
    .ref_clk (ref_clk),
    .rst     (rst),
    .init    (state_q == ST_EXEC),
    .en      (byteDone && (state_q == ST_EMIT)),
    .data    (payByte),
    .crc_q   (txCrc)
  );

  // Register access request lines
  assign regReq   = (state_q == ST_FETCH);
  assign regWrite = (kind_q == RK_WR);
  assign regWData = {buf_q[4], buf_q[5]};

  // Main sequencer
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_q      <= ST_RX;
      kind_q       <= RK_EX;
      excCode_q    <= '0;
      regAddr      <= '0;
      word_q       <= '0;
      wordReady_q  <= 1'b0;
      started_q    <= 1'b0;
      frameDone    <= 1'b0;
      frameDropped <= 1'b0;
    end else begin
      frameDone    <= 1'b0;
      frameDropped <= 1'b0;
      case (state_q)
        ST_RX: begin
          if (rxEnd) state_q <= ST_EXEC;
        end
        ST_EXEC: begin
          started_q   <= 1'b0;
          wordReady_q <= 1'b0;
          regAddr     <= {buf_q[2], buf_q[3]};
          kind_q      <= RK_EX;
          excCode_q   <= `MSF_EXC_DATA;
          state_q     <= bcast ? ST_RX : ST_START;
          if (bad_q || !checkOk || !addrOk) begin
            frameDropped <= 1'b1;
            state_q      <= ST_RX;
          end else begin
            frameDone <= 1'b1;
            if (frmErr_q || parErr_q) begin
              excCode_q <= frmErr_q ? `MSF_EXC_FRAME : `MSF_EXC_PARITY;
            end else if ((buf_q[1] == `MSF_FN_READ) && (dataLen == `MSF_REQ_DLEN) &&
                         (buf_q[4] == 8'h00) && (buf_q[5] != 8'h00) &&
                         (buf_q[5] <= `MSF_MAX_WORDS)) begin
              kind_q  <= RK_RD;
              state_q <= bcast ? ST_RX : ST_FETCH;
            end else if ((buf_q[1] == `MSF_FN_WRITE) && (dataLen == `MSF_REQ_DLEN)) begin
              kind_q  <= RK_WR;
              state_q <= ST_FETCH;
            end
          end
        end
        ST_FETCH: begin
          if (regAck) begin
            word_q      <= regRData;
            wordReady_q <= 1'b1;
            if (kind_q == RK_RD) regAddr <= regAddr + 16'h0001;
            if (!started_q && (regAddrErr || regDataErr)) begin
              kind_q    <= RK_EX;
              excCode_q <= regAddrErr ? `MSF_EXC_ADDR : `MSF_EXC_DATA;
              state_q   <= bcast ? ST_RX : ST_START;
            end else if (kind_q == RK_WR) begin
              state_q <= bcast ? ST_RX : ST_START;
            end else begin
              state_q <= started_q ? ST_EMIT : ST_START;
            end
          end
        end
        ST_START: begin
          started_q <= 1'b1;
          if (fire || !asciiMode) state_q <= ST_EMIT;
        end
        ST_EMIT: begin
          if (needFetch) begin
            state_q <= ST_FETCH;
          end else if (byteDone) begin
            if ((kind_q == RK_RD) && (k_q >= 5'h03) && !k_q[0]) wordReady_q <= 1'b0;
            if (k_q == payLen - 5'h01) state_q <= ST_TRAIL;
          end
        end
        ST_TRAIL: begin
          if (byteDone && lastTrail) state_q <= ST_DRAIN;
        end
        ST_DRAIN: begin
          // RTU keeps the line quiet after its own frame before listening again
          if (!txValid && (asciiMode || gapHit)) state_q <= ST_RX;
        end
        default: begin
          state_q <= ST_RX;
        end
      endcase
    end
  end

  // Emission counters and transmit LRC
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      k_q      <= '0;
      tIdx_q   <= '0;
      nibSel_q <= 1'b0;
      txLrc_q  <= '0;
    end else if (state_q == ST_EXEC) begin
      k_q      <= '0;
      tIdx_q   <= '0;
      nibSel_q <= 1'b0;
      txLrc_q  <= '0;
    end else begin
      if (fire && hexMode) nibSel_q <= !nibSel_q;
      if (byteDone && (state_q == ST_EMIT)) begin
        k_q     <= k_q + 5'h01;
        txLrc_q <= txLrc_q + payByte;
      end
      if (byteDone && (state_q == ST_TRAIL)) tIdx_q <= tIdx_q + 2'h1;
    end
  end

  // Word frame length for the serial engine
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      charBits <= `MSF_ASCII_BITS;
    end else begin
      charBits <= asciiMode ? `MSF_ASCII_BITS : `MSF_RTU_BITS;
    end
  end

  // Transmit buffer absorbs stalls of the serial engine
  assign chIn.valid  = chValid;
  assign chIn.data   = chData;
  assign fifoReady   = chIn.ready;
  assign txValid     = chOut.valid;
  assign txData      = chOut.data;
  assign chOut.ready = txReady;

  msf_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) u_txFifo (
    .ref_clk (ref_clk),
    .rst     (rst),
    .inp     (chIn),
    .outp    (chOut)
  );

endmodule
`default_nettype wire

/* verif/msf_framer_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module msf_framer_chk (
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        rst,
  // Mode and transmit side
  input wire logic        asciiMode,
  input wire logic [3:0]  charBits,
  input wire logic        txValid,
  input wire logic [7:0]  txData,
  input wire logic        txReady,
  // Register side and status
  input wire logic        regReq,
  input wire logic        regWrite,
  input wire logic [15:0] regAddr,
  input wire logic        regAck,
  input wire logic        frameDone,
  input wire logic        frameDropped
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  // Word frame length follows the mode one cycle late
  a_frame_len: assert property (
    $stable(asciiMode) && !$past(rst) |-> charBits == (asciiMode ? 4'hA : 4'hB))
    else $error("word frame length wrong");
  a_status_excl: assert property (
    frameDone |-> !frameDropped ##1 (!frameDone && !frameDropped))
    else $error("status pulse wrong");
  a_tx_hold: assert property (
    txValid && !txReady |=> txValid && $stable(txData))
    else $error("reply byte changed while stalled");
  a_req_hold: assert property (
    regReq && !regAck |=> regReq && $stable(regAddr) && $stable(regWrite))
    else $error("register request not held");
  a_req_release: assert property (
    regReq && regAck |=> !regReq)
    else $error("register request not released");
  a_ascii_chars: assert property (
    asciiMode && txValid |-> txData inside {[8'h30:8'h39], [8'h41:8'h46], 8'h3A, 8'h0D, 8'h0A})
    else $error("illegal ascii character sent");
  // A discarded frame produces no reply for eight cycles and no register access for five
  a_drop_silent: assert property (
    frameDropped |-> !txValid [*8])
    else $error("reply after dropped frame");
  a_drop_noreq: assert property (
    frameDropped |-> !regReq ##1 !regReq [*4])
    else $error("register access after dropped frame");

  c_done: cover property (frameDone);
  c_drop: cover property (frameDropped);
  c_write: cover property (regReq && regAck && regWrite);
  c_stall: cover property (txValid && !txReady);
endmodule

bind msf_framer msf_framer_chk chk (
  .ref_clk(ref_clk), .rst(rst), .asciiMode(asciiMode), .charBits(charBits),
  .txValid(txValid), .txData(txData), .txReady(txReady), .regReq(regReq),
  .regWrite(regWrite), .regAddr(regAddr), .regAck(regAck),
  .frameDone(frameDone), .frameDropped(frameDropped));
`default_nettype wire

/* verif/msf_master_mdl.sv */
`timescale 1ns/1ps
`default_nettype none
module msf_master_mdl (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Reply stream acceptance
  output logic     txReady
);
  int seed = 95;

  initial txReady = 1'b0;

  // Stall about one cycle in four so the reply FIFO really backs up
  always @(posedge ref_clk) begin
    txReady <= #1 !rst && (($random(seed) % 4) != 0);
  end
endmodule
`default_nettype wire

/* verif/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int GAP = 40;
  logic        ref_clk = 1'b0, rst = 1'b1, asciiMode = 1'b0, rxValid = 1'b0;
  logic        rxFrameErr = 1'b0, regAck = 1'b0, regAddrErr = 1'b0, errA = 1'b0;
  logic        rxParityErr = 1'b0, regDataErr = 1'b0, errD = 1'b0;
  logic [3:0]  charBits;
  logic [7:0]  rxData = 8'h00, stationAddr = 8'h01;
  logic [15:0] regRData = 16'h0000;
  logic        txValid, txReady, regReq, regWrite, frameDone, frameDropped;
  logic [7:0]  txData;
  logic [15:0] regAddr, regWData;
  logic [7:0]  qExp[$], qSt[$], e[$];
  logic [15:0] qWr[$];
  int          fails = 0, checked = 0, seed = 95, wcnt = 0;

  always #5 ref_clk = ~ref_clk;

  msf_framer #(.GAP_CYCLES(GAP), .FIFO_DEPTH(8)) dut (
    .ref_clk(ref_clk), .rst(rst), .asciiMode(asciiMode), .stationAddr(stationAddr),
    .charBits(charBits), .rxValid(rxValid), .rxData(rxData), .rxFrameErr(rxFrameErr),
    .rxParityErr(rxParityErr), .txValid(txValid), .txData(txData), .txReady(txReady),
    .regReq(regReq), .regWrite(regWrite), .regAddr(regAddr), .regWData(regWData),
    .regAck(regAck), .regRData(regRData), .regAddrErr(regAddrErr),
    .regDataErr(regDataErr),
    .frameDone(frameDone), .frameDropped(frameDropped));

  msf_master_mdl mdl (.ref_clk(ref_clk), .rst(rst), .txReady(txReady));

  task automatic cmpB(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t byte %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmpW(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t word %h expected %h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Register side answers after a random wait; read data is a fixed mix of the address
  always @(posedge ref_clk) begin
    if (regReq && !regAck && wcnt == 0) begin
      regAck <= #1 1'b1;
      regRData <= #1 regAddr ^ 16'hC3C3;
      regAddrErr <= #1 errA;
      regDataErr <= #1 errD;
      wcnt <= #1 {$random(seed)} % 4;
    end else begin
      regAck <= #1 1'b0;
      if (regReq && wcnt > 0) wcnt <= #1 wcnt - 1;
    end
  end

  // Watcher: each result takes the oldest note of its kind
  always @(posedge ref_clk) begin
    if (txValid && txReady) cmpB(txData, qExp.size() ? qExp.pop_front() : 8'hxx);
    if (frameDone || frameDropped)
      cmpB({6'h00, frameDone, frameDropped}, qSt.size() ? qSt.pop_front() : 8'hxx);
    if (regReq && regAck && regWrite) begin
      cmpW(regAddr, qWr.size() ? qWr.pop_front() : 16'hxxxx);
      cmpW(regWData, qWr.size() ? qWr.pop_front() : 16'hxxxx);
    end
  end

  function automatic logic [7:0] hx(input logic [3:0] n);
    return (n < 4'hA) ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
  endfunction

  // Wraps a payload into a whole frame in e; bad spoils the check value
  function automatic void enc(input logic [7:0] p[$], input logic bad);
    logic [15:0] c;
    logic [7:0]  s;
    c = 16'hFFFF;
    s = 8'h00;
    e.delete();
    if (asciiMode) e.push_back(8'h3A);
    foreach (p[i]) begin
      s = s + p[i];
      c = c ^ {8'h00, p[i]};
      for (int j = 0; j < 8; j++) c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
      if (asciiMode) begin
        e.push_back(hx(p[i][7:4]));
        e.push_back(hx(p[i][3:0]));
      end else e.push_back(p[i]);
    end
    s = (8'h00 - s) ^ {7'h00, bad};
    c = c ^ {15'h0000, bad};
    if (asciiMode) e = {e, hx(s[7:4]), hx(s[3:0]), 8'h0D, 8'h0A};
    else e = {e, c[7:0], c[15:8]};
  endfunction

  // One character per cycle; fe and pe mark a framing or parity error early in the frame
  task automatic sendE(input logic fe, input logic pe);
    foreach (e[i]) begin
      @(posedge ref_clk);
      #1 rxValid = 1'b1;
      rxData = e[i];
      rxFrameErr = fe && (i == 1);
      rxParityErr = pe && (i == 2);
    end
    @(posedge ref_clk);
    #1 rxValid = 1'b0;
    rxFrameErr = 1'b0;
    rxParityErr = 1'b0;
  endtask

  // k: 0 reply, >0 exception code, -1 other station, -2 bad check, -3 broadcast
  task automatic txn(input logic [7:0] a, f, input logic [15:0] p1, p2, input int k);
    logic [7:0]  p[$];
    logic [7:0]  r[$];
    logic [15:0] d;
    int          n;
    p = '{a, f, p1[15:8], p1[7:0], p2[15:8], p2[7:0]};
    errA = (k == 2);
    errD = (k == 1);
    repeat (GAP + 10) @(posedge ref_clk);
    cmpB({4'h0, charBits}, asciiMode ? 8'h0A : 8'h0B);
    if (asciiMode) begin
      e = '{8'h3A, 8'h30, 8'h37};
      sendE(1'b0, 1'b0);
    end
    qSt.push_back((k == -1 || k == -2) ? 8'h01 : 8'h02);
    if (f == 8'h06 && (k inside {0, 1, 2, -3})) qWr = {qWr, p1, p2};
    enc(p, k == -2);
    sendE(k == 11, k == 12);
    if (k == 0 && f == 8'h03) begin
      r = '{a, f, {p2[6:0], 1'b0}};
      for (int w = 0; w < p2; w++) begin
        d = (p1 + w[15:0]) ^ 16'hC3C3;
        r = {r, d[15:8], d[7:0]};
      end
    end else if (k == 0) r = p;
    else if (k > 0) r = '{a, f | 8'h80, k[7:0]};
    if (r.size() > 0) begin
      enc(r, 1'b0);
      qExp = {qExp, e};
    end
    n = 0;
    while (qExp.size() + qSt.size() > 0 && n < 3000) begin
      @(posedge ref_clk);
      n++;
    end
    repeat (20) @(posedge ref_clk);
    cmpB(8'(qExp.size() + qSt.size() + qWr.size()), 8'h00);
    qExp.delete();
    qSt.delete();
    qWr.delete();
    $display("test ascii=%0d addr=%h fn=%h kind=%0d ended", asciiMode, a, f, k);
  endtask

  initial begin
    repeat (5) @(posedge ref_clk);
    #1 rst = 1'b0;
    for (int m = 0; m < 2; m++) begin
      @(posedge ref_clk);
      #1 asciiMode = m[0];
      txn(8'h01, 8'h03, 16'h100E, 16'h0002, 0);
      txn(8'h01, 8'h03, 16'hFFF8, 16'h0008, 0);
      txn(8'h01, 8'h06, 16'h0064, 16'($random(seed)), 0);
      txn(8'h01, 8'h06, 16'h0064, 16'h1770, -2);
      txn(8'h02, 8'h03, 16'h100E, 16'h0001, -1);
      txn(8'h00, 8'h06, 16'h0001, 16'($random(seed)), -3);
      txn(8'h01, 8'h05, 16'h0000, 16'h0000, 1);
      txn(8'h01, 8'h03, 16'h0000, 16'h0009, 1);
      txn(8'h01, 8'h06, 16'h0100, 16'h0001, 2);
      txn(8'h01, 8'h03, 16'h0000, 16'h0001, 11);
      txn(8'h01, 8'h03, 16'h0000, 16'h0001, 12);
      txn(8'h01, 8'h06, 16'h0064, 16'h0002, 1);
    end
    report_and_stop();
  end

  // Watchdog well beyond the expected run of some three thousand cycles
  initial begin
    #300000;
    fails++;
    report_and_stop();
  end
endmodule
`default_nettype wire
